// File: rtl/scaa_safing_core.sv
// Safing comparator, sample counters and dwell-extended arming outputs
`timescale 1ns/1ns
// Contract
// - Threshold gets a zero prepended as MSB
// - Compare only on frame, valid, no error
// - Unsigned 9-bit magnitude comparison
// - 10-bit frame data converted to 9-bit magnitude
// - Sixteen 2-bit counters, one per sequence ID
// - Counter increments when sample exceeds threshold
// - Counter at 11 arms, inhibit goes low
// - Counters saturate, never wrap
// - Counter clears on reset or non-exceeding sample
// - Dwell only in safing mode, not diagnostic
// - Arm while saturated, then for dwell time
// - Threshold bit 7 picks 255 ms or 2 s
// - Mixed selections while armed use the longer dwell; a re-arm during dwell takes the new selection
// - Valid data only when status bits are 01
// - Eight thresholds, one per sequence pair

`include "scaa_defines.svh"

module scaa_safing_core #(
    parameter int TICK_CYC  = `SCAA_TICK_MS_CYC,
    parameter int SHORT_MS  = `SCAA_DWELL_SHORT_MS,
    parameter int LONG_MS   = `SCAA_DWELL_LONG_MS
) (
    // Clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 NRST,

    // Sample from the SPI monitor
    input  wire logic                 SAMPLE_STROBE,
    input  wire logic [3:0]           SEQUENCE_ID,
    input  wire logic [1:0]           SENSOR_STATUS_BITS,
    input  wire logic [9:0]           SENSOR_DATA,
    input  wire logic                 SEQUENCE_ERROR,

    // Threshold slots, one per sequence pair
    input  wire scaa_pkg::scaa_thresh_type THRESHOLD [8],

    // Mode
    input  wire logic                 SAFING_MODE,

    // Arming pair and per-ID saturation flags
    output logic                      ARM_OUT,
    output logic                      SAFING_INHIBIT_OUT,
    output logic [15:0]               SATURATED
);
    import scaa_pkg::*;

    // =============================================================
    // Local sizes
    localparam int NUM_ID   = 16;
    localparam int NUM_SLOT = NUM_ID / 2;
    localparam int MAX_MS   = (LONG_MS > SHORT_MS) ? LONG_MS : SHORT_MS;
    localparam int DW       = $clog2(MAX_MS + 1);
    localparam int TW       = $clog2(TICK_CYC + 1);
    localparam logic [DW-1:0]     DW_ONE   = DW'(1);
    localparam logic [NUM_ID-1:0] SAT_NONE = '0;

    // =============================================================
    // Decoding helpers
    // Two consecutive sequence IDs share one threshold slot
    function automatic logic [2:0] slot_of(input logic [3:0] id);
        logic [2:0] slot;
        slot = id[3:1];
        return slot;
    endfunction

    // Negative samples clamp to zero, so they can never arm
    function automatic logic [8:0] to_magnitude(input logic [9:0] raw);
        logic [8:0] mag;
        if (raw[9]) begin
            mag = 9'h000;
        end else begin
            mag = raw[8:0];
        end
        return mag;
    endfunction

    // Top bit of a slot picks the long dwell
    function automatic logic dwell_long(input scaa_thresh_type thr);
        logic sel;
        sel = thr[`SCAA_DWELL_SEL_BIT];
        return sel;
    endfunction

    // =============================================================
    // Sample qualification
    logic status_ok;
    logic cmp_en;

    always_comb begin
        status_ok = (SENSOR_STATUS_BITS == `SCAA_STATUS_VALID);
        cmp_en    = SAMPLE_STROBE && !SEQUENCE_ERROR && status_ok;
    end

    // =============================================================
    // Magnitude compare
    logic            exceed;
    logic [8:0]      thr_ext;
    logic [8:0]      sample_mag;
    scaa_thresh_type thr_sel;

    always_comb begin
        // The stored slot already holds half the wanted value
        thr_sel    = THRESHOLD[slot_of(SEQUENCE_ID)];
        thr_ext    = {1'b0, thr_sel};
        sample_mag = to_magnitude(SENSOR_DATA);
        // Equal to the threshold does not count as exceeding
        exceed     = (sample_mag > thr_ext);
    end

    // =============================================================
    // Sample counters, one per sequence ID
    // A counter moves only on a sample that carries its own ID
    logic [NUM_ID-1:0] sat;

    genvar g;
    generate
        for (g = 0; g < NUM_ID; g++) begin : g_cnt
            logic [1:0] cnt_q;
            logic [1:0] cnt_d;
            logic       own;

            always_comb begin
                own   = cmp_en && (SEQUENCE_ID == 4'(g));
                cnt_d = cnt_q;
                if (own) begin
                    if (!exceed) begin
                        cnt_d = 2'h0;
                    end else if (cnt_q != `SCAA_CNT_SAT) begin
                        cnt_d = cnt_q + 2'h1;
                    end
                end
            end

            always_ff @(posedge SYS_CLK) begin
                if (!NRST) begin
                    cnt_q <= 2'h0;
                end else begin
                    cnt_q <= cnt_d;
                end
            end

            assign sat[g] = (cnt_q == `SCAA_CNT_SAT);
        end
    endgenerate

    // =============================================================
    // Per-slot dwell flags
    logic [NUM_SLOT-1:0] slot_long;

    genvar s;
    generate
        for (s = 0; s < NUM_SLOT; s++) begin : g_slot
            assign slot_long[s] = dwell_long(THRESHOLD[s]);
        end
    endgenerate

    // =============================================================
    // Saturation summary and dwell selection
    logic any_sat;
    logic long_sel;

    always_comb begin
        any_sat  = |sat;
        long_sel = 1'b0;
        // Any saturated ID whose slot asks for long wins
        for (int i = 0; i < NUM_ID; i++) begin
            if (sat[i] && slot_long[slot_of(4'(i))]) begin
                long_sel = 1'b1;
            end
        end
    end

    // =============================================================
    // Millisecond tick
    // Free running, so the first dwell millisecond may be short
    logic [TW-1:0] tick_cnt_q;
    logic [TW-1:0] tick_cnt_d;
    logic          tick;

    always_comb begin
        tick = (tick_cnt_q == TW'(TICK_CYC - 1));
        if (tick) begin
            tick_cnt_d = '0;
        end else begin
            tick_cnt_d = tick_cnt_q + TW'(1);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // =============================================================
    // Arming state machine
    scaa_state_type state_q;
    scaa_state_type state_d;
    logic [DW-1:0]  dwell_q;
    logic [DW-1:0]  dwell_d;
    logic [DW-1:0]  reload_val;
    logic           long_q;
    logic           long_d;
    logic           arm_d;

    // Reload value for the dwell countdown
    always_comb begin
        if (long_q) begin
            reload_val = DW'(LONG_MS);
        end else begin
            reload_val = DW'(SHORT_MS);
        end
    end

    always_comb begin
        state_d = state_q;
        dwell_d = dwell_q;
        long_d  = long_q;
        unique case (state_q)
            SCAA_IDLE: begin
                if (any_sat) begin
                    state_d = SCAA_ARMED;
                    long_d  = long_sel;
                end
            end
            SCAA_ARMED: begin
                // Keep the longest selection seen while armed
                long_d = long_q | long_sel;
                if (!any_sat) begin
                    if (SAFING_MODE) begin
                        state_d = SCAA_DWELL;
                        dwell_d = reload_val;
                    end else begin
                        // Diagnostic mode drops arming with no dwell
                        state_d = SCAA_IDLE;
                    end
                end
            end
            SCAA_DWELL: begin
                if (any_sat) begin
                    // Fresh saturation re-arms; dwell reloads later
                    state_d = SCAA_ARMED;
                    long_d  = long_sel;
                end else if (!SAFING_MODE) begin
                    // Leaving safing mode cuts the dwell short
                    state_d = SCAA_IDLE;
                end else if (tick) begin
                    if (dwell_q <= DW_ONE) begin
                        state_d = SCAA_IDLE;
                    end
                    dwell_d = dwell_q - DW_ONE;
                end
            end
        endcase
        arm_d = (state_d != SCAA_IDLE);
    end

    always_ff @(posedge SYS_CLK) begin
        // Count and long flag clear together with the state
        if (!NRST) begin
            state_q <= SCAA_IDLE;
            dwell_q <= '0;
            long_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            dwell_q <= dwell_d;
            long_q  <= long_d;
        end
    end

    // =============================================================
    // Output registers
    // Every output leaves straight from a flip-flop
    logic              inhibit_d;
    logic [NUM_ID-1:0] sat_out_d;

    always_comb begin
        inhibit_d = !arm_d;
        sat_out_d = sat;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ARM_OUT            <= 1'b0;
            SAFING_INHIBIT_OUT <= 1'b1;
            SATURATED          <= SAT_NONE;
        end else begin
            ARM_OUT            <= arm_d;
            SAFING_INHIBIT_OUT <= inhibit_d;
            SATURATED          <= sat_out_d;
        end
    end

endmodule // scaa_safing_core

// File: rtl/scaa_defines.svh
// Constants for the safing compare and arming block
`ifndef SCAA_DEFINES_SVH
`define SCAA_DEFINES_SVH

// =============================================================
// Timing
`define SCAA_CLK_HZ        50000000
`define SCAA_TICK_MS_CYC   (`SCAA_CLK_HZ / 1000)
`define SCAA_DWELL_SHORT_MS 255
`define SCAA_DWELL_LONG_MS  2000

// =============================================================
// Fields
`define SCAA_STATUS_VALID  2'h1
`define SCAA_DWELL_SEL_BIT 7
`define SCAA_CNT_SAT       2'h3

`endif

// File: rtl/scaa_pkg.sv
// Types for the safing compare and arming block
package scaa_pkg;
    typedef enum logic [1:0] {
        SCAA_IDLE,
        SCAA_ARMED,
        SCAA_DWELL
    } scaa_state_type;
    typedef logic [7:0] scaa_thresh_type;
endpackage

// File: bench/scaa_asserts.sv
// Checker for the safing compare and arming block
`timescale 1ns/1ns
module scaa_asserts #(
    parameter int TICK_CYC = 4,
    parameter int LONG_MS  = 6
) (
    // Clock, reset, sample
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    input wire logic        SAMPLE_STROBE,
    input wire logic [1:0]  SENSOR_STATUS_BITS,
    input wire logic        SEQUENCE_ERROR,
    // Mode and arming
    input wire logic        SAFING_MODE,
    input wire logic        ARM_OUT,
    input wire logic        SAFING_INHIBIT_OUT,
    input wire logic [15:0] SATURATED
);
    // =========
    // Properties
    localparam int DW_MAX = (LONG_MS + 1) * TICK_CYC + 4;
    wire take = SAMPLE_STROBE & ~SEQUENCE_ERROR
              & (SENSOR_STATUS_BITS == 2'h1);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    sequence s_drop;
        SAFING_MODE && $fell(|SATURATED);
    endsequence
    a_pair_inv: assert property (SAFING_INHIBIT_OUT == !ARM_OUT)
        else $error("Inhibit not inverse of arm");
    a_sat_arms: assert property (|SATURATED |-> ARM_OUT)
        else $error("Saturated without arm");
    a_rise_cause: assert property ($rose(ARM_OUT) |-> |SATURATED)
        else $error("Arm rose without saturation");
    a_sat_cause:
        assert property (|(SATURATED & ~$past(SATURATED))
            |-> $past(take) || $past(take, 2))
        else $error("Saturation without taken sample");
    a_diag_drop:
        assert property (!SAFING_MODE && $past(!SAFING_MODE)
            && !(|SATURATED) |-> !ARM_OUT)
        else $error("Dwell seen in diagnostic mode");
    a_dwell_min: assert property (s_drop |-> ARM_OUT[*6])
        else $error("Dwell too short");
    a_dwell_max:
        assert property (s_drop |-> ##[1:DW_MAX] (!ARM_OUT || |SATURATED))
        else $error("Dwell too long");
    a_reset_idle:
        assert property (disable iff (1'b0)
            !NRST |=> !ARM_OUT && SATURATED == 16'h0)
        else $error("Reset did not clear");
endmodule // scaa_asserts
bind scaa_safing_core scaa_asserts #(.TICK_CYC(TICK_CYC), .LONG_MS(LONG_MS))
    u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .SAMPLE_STROBE(SAMPLE_STROBE),
    .SENSOR_STATUS_BITS(SENSOR_STATUS_BITS), .SEQUENCE_ERROR(SEQUENCE_ERROR),
    .SAFING_MODE(SAFING_MODE), .ARM_OUT(ARM_OUT),
    .SAFING_INHIBIT_OUT(SAFING_INHIBIT_OUT), .SATURATED(SATURATED));

// File: bench/scaa_feed.sv
// Threshold loader model for the block's far side
`timescale 1ns/1ns
module scaa_feed (
    // Desired values and long-dwell choice per slot
    input  wire logic [8:0]           want [8],
    input  wire logic [7:0]           lng,
    // Encoded slots
    output scaa_pkg::scaa_thresh_type thr  [8]
);
    // Halving drops the low bit, so odd wishes round down
    always_comb
        for (int k = 0; k < 8; k++) thr[k] = {lng[k], want[k][7:1]};
endmodule // scaa_feed

// File: bench/safing_compare_and_arming_tb.sv
// Self-checking bench for the safing compare and arming block
`timescale 1ns/1ns
module safing_compare_and_arming_tb;
    import scaa_pkg::*;
    typedef struct packed {
        logic v; int lo; int hi; logic [15:0] m;
    } scaa_note_type;
    logic clk = 0, nrst = 0, stb = 0, err = 0, mode = 1, last = 0, arm, inh;
    logic [3:0] id = 0;
    logic [1:0] st = 0;
    logic [9:0] dat = 0;
    logic [8:0] want [8];
    logic [15:0] sat;
    logic [31:0] rs = 32'h20bfb6c4;
    scaa_thresh_type thr [8];
    scaa_note_type q [$];
    int err_count = 0, samples_checked = 0, cyc = 0;
    always #10 clk = ~clk;
    scaa_feed u_feed (.want(want), .lng(8'h04), .thr(thr));
    // Short counts keep dwell windows to a few dozen cycles
    scaa_safing_core #(.TICK_CYC(4), .SHORT_MS(3), .LONG_MS(6)) u_dut (
        .SYS_CLK(clk), .NRST(nrst), .SAMPLE_STROBE(stb), .SEQUENCE_ID(id),
        .SENSOR_STATUS_BITS(st), .SENSOR_DATA(dat), .SEQUENCE_ERROR(err),
        .THRESHOLD(thr), .SAFING_MODE(mode), .ARM_OUT(arm),
        .SAFING_INHIBIT_OUT(inh), .SATURATED(sat));
    // =========
    // Tasks
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic bad(string m);
        err_count++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic smp(logic [3:0] i, logic [9:0] d, logic [1:0] s = 2'h1,
                       logic e = 1'b0);
        @(posedge clk);
        {stb, id, dat, st, err} <= {1'b1, i, d, s, e};
    endtask
    // Window is in cycles after the last sample issued
    task automatic ex(logic v, int lo, int hi, logic [15:0] m = 16'h0000);
        q.push_back({v, cyc + lo, cyc + hi, m});
    endtask
    task automatic fin(string s);
        repeat (40) @(posedge clk) stb <= 1'b0;
        $display("Test done: %s", s);
    endtask
    task automatic cmp_sat(logic [15:0] m);
        samples_checked++;
        if (sat !== m) bad("Saturated set off");
    endtask
    task automatic cmp_inh();
        samples_checked++;
        if (inh !== ~arm) bad("Inhibit not inverse of arm");
    endtask
    task automatic cmp_arm();
        scaa_note_type n;
        samples_checked++;
        if (q.size() == 0) bad("Arm moved unexpectedly");
        else begin
            n = q.pop_front();
            if (arm !== n.v || cyc < n.lo || cyc > n.hi) bad("Arm change off");
            cmp_sat(n.m);
        end
    endtask
    // =========
    // Watcher
    always @(posedge clk) begin
        cyc <= cyc + 1;
        last <= arm;
        if (cyc == 2000) begin
            bad("Timeout");
            report_and_stop();
        end
        if (nrst === 1'b1 && arm !== last) cmp_arm();
        if (nrst === 1'b1) cmp_inh();
    end
    // =========
    // Scenarios
    initial begin
        for (int k = 0; k < 8; k++) want[k] = 9'(40 + 20 * k);
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) smp(3, 100);
        ex(1, 1, 4, 16'h0008);
        repeat (2) smp(3, 100);
        smp(3, 30);
        ex(0, 8, 17);
        fin("short dwell");
        smp(6, 51);
        smp(6, 10'h3ff);
        smp(6, 51);
        smp(6, 51, 2'h2);
        smp(6, 51, 2'h1, 1'b1);
        smp(6, 51);
        smp(7, 60);
        smp(6, 51);
        ex(1, 1, 4, 16'h0040);
        smp(6, 0);
        smp(7, 0);
        ex(0, 8, 17);
        fin("refused samples");
        repeat (2) begin
            smp(4, 169);
            smp(0, 21);
        end
        smp(4, 169);
        ex(1, 1, 4, 16'h0010);
        smp(0, 21);
        smp(4, 0);
        smp(0, 0);
        ex(0, 20, 29);
        fin("long dwell");
        mode <= 1'b0;
        repeat (3) smp(9, 61);
        ex(1, 1, 4, 16'h0200);
        smp(9, 60);
        ex(0, 1, 4);
        fin("diagnostic");
        mode <= 1'b1;
        // Never above threshold, so arm must stay low
        repeat (60) begin
            rs = xs(rs);
            smp(rs[3:0], rs[4] ? {1'b1, rs[13:5]}
                : 10'(rs[13:5] % ({1'b0, thr[rs[3:1]]} + 9'h1)),
                rs[15:14], rs[16]);
        end
        fin("random");
        samples_checked++;
        if (q.size() != 0) bad("Arm change missing");
        report_and_stop();
    end
endmodule // safing_compare_and_arming_tb
